// ### shared/shift_move_pkg.sv
package shift_move_pkg;
   // ==========================================
   // bus geometry
   localparam int APB_AW = 8;
   localparam int DATA_W = 8;
   localparam int PTR_W = 16;

   // ==========================================
   // register offsets
   localparam logic [APB_AW-1:0] OFF_CMD = 8'h00;
   localparam logic [APB_AW-1:0] OFF_STATUS = 8'h04;
   localparam logic [APB_AW-1:0] OFF_PTR0 = 8'h08;
   localparam logic [APB_AW-1:0] OFF_PTR1 = 8'h0C;
   localparam logic [APB_AW-1:0] OFF_MEM_ADDR = 8'h10;
   localparam logic [APB_AW-1:0] OFF_MEM_DATA = 8'h14;

   // ==========================================
   // file address map
   localparam logic [6:0] IND_LOC0 = 7'h00;
   localparam logic [6:0] IND_LOC1 = 7'h01;

   // ==========================================
   // pointer update modes
   localparam logic [1:0] MODE_PRE_INC = 2'h0;
   localparam logic [1:0] MODE_PRE_DEC = 2'h1;
   localparam logic [1:0] MODE_POST_INC = 2'h2;
   localparam logic [1:0] MODE_POST_DEC = 2'h3;

   // ==========================================
   // reset values
   localparam logic [7:0] RST_WORKING = 8'h00;
   localparam logic [4:0] RST_BANK = 5'h00;
   localparam logic [6:0] RST_PC_HIGH = 7'h00;
   localparam logic [15:0] RST_PTR = 16'h0000;

   // ==========================================
   // command word
   typedef enum logic [2:0] {
      OP_IDLE,
      OP_SHIFT_RIGHT,
      OP_INDIRECT_LOAD,
      OP_LIT_BANK,
      OP_LIT_LATCH,
      OP_LIT_WORKING,
      OP_STORE_WORKING
   } op_t;

   typedef struct packed {
      logic [4:0] spare_hi;
      op_t op;
      logic dest;
      logic ptr_sel;
      logic [1:0] pointer_update_mode;
      logic relative;
      logic [10:0] spare_lo;
      logic [7:0] operand;
   } cmd_t;

   // ==========================================
   // block state
   typedef struct packed {
      logic [7:0] working;
      logic carry;
      logic zero;
      logic [4:0] bank_select_register;
      logic [6:0] program_counter_high_latch;
      logic [15:0] ptr0;
      logic [15:0] ptr1;
      logic [15:0] mem_addr;
      logic [31:0] rdata;
      logic ready;
      logic slverr;
   } state_t;

   localparam state_t STATE_RESET = '{
      working: RST_WORKING,
      carry: 1'b0,
      zero: 1'b0,
      bank_select_register: RST_BANK,
      program_counter_high_latch: RST_PC_HIGH,
      ptr0: RST_PTR,
      ptr1: RST_PTR,
      mem_addr: RST_PTR,
      rdata: 32'h0000_0000,
      ready: 1'b0,
      slverr: 1'b0
   };
endpackage

// ### rtl/shift_move_datapath.sv
`timescale 1ns/10ps
// What this block does
// - right shift: bits 7:1 to 6:0, zero into bit 7, bit 0 to carry, zero flag
// - shift reads file register picked by 7-bit operand, one place toward lsb
// - destination bit 0: result to working register, file register untouched
// - destination bit 1: result written back to the same file register
// - indirect load copies byte at chosen pointer into working, sets zero flag
// - mode 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec
// - relative form addresses pointer plus signed offset -32..31
// - pointer ends one up or one down; relative form leaves it unchanged
// - indirect locations hold nothing; access goes to pointer's address
// - pointer arithmetic wraps within 0000h..FFFFh
// - bank literal loads 5-bit value into bank select, flags untouched
// - latch literal loads 7-bit value into pc high latch, flags untouched
// - working literal loads 8-bit value in one cycle, flags untouched
// - store copies working into addressed file register, flags untouched
// - pointer stepping never changes carry, zero or other status
module shift_move_datapath #(
   parameter int DEPTH = 256
) (
   input wire logic CLK,
   input wire logic NRST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [shift_move_pkg::APB_AW-1:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR
);
   import shift_move_pkg::*;

   localparam int AW = $clog2(DEPTH);

   // ==========================================
   // parameter check
   if (DEPTH < 2 || DEPTH > 65536 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
      $error("DEPTH must be a power of two from 2 to 65536");
   end
   if (DATA_W != 8) begin : g_bad_data
      $error("datapath is built for 8-bit data");
   end
   if (PTR_W != 16) begin : g_bad_ptr
      $error("pointers are built for 16-bit values");
   end
   if (APB_AW < 5) begin : g_bad_aw
      $error("bus address too narrow for the register map");
   end
   if (IND_LOC0 == IND_LOC1) begin : g_bad_loc
      $error("indirect locations must differ");
   end

   // ==========================================
   // helpers
   function automatic logic [AW-1:0] mem_index(input logic [15:0] a);
      return a[AW-1:0];
   endfunction

   function automatic logic [15:0] file_addr(input logic [4:0] bank,
                                             input logic [6:0] f,
                                             input logic [15:0] p0,
                                             input logic [15:0] p1);
      logic [15:0] a;
      a = {4'h0, bank, f};
      if (f == IND_LOC0) begin
         a = p0;
      end else if (f == IND_LOC1) begin
         a = p1;
      end
      return a;
   endfunction

   function automatic logic mapped(input logic [APB_AW-1:0] a);
      logic hit;
      case (a)
         OFF_CMD: hit = 1'b1;
         OFF_STATUS: hit = 1'b1;
         OFF_PTR0: hit = 1'b1;
         OFF_PTR1: hit = 1'b1;
         OFF_MEM_ADDR: hit = 1'b1;
         OFF_MEM_DATA: hit = 1'b1;
         default: hit = 1'b0;
      endcase
      return hit;
   endfunction

   function automatic logic is_zero(input logic [7:0] v);
      return v == 8'h00;
   endfunction

   function automatic logic [7:0] shift_right(input logic [7:0] v);
      return {1'b0, v[7:1]};
   endfunction

   function automatic logic [15:0] step_ptr(input logic [15:0] p,
                                            input logic down);
      logic [15:0] r;
      if (down) begin
         r = p - 16'h0001;
      end else begin
         r = p + 16'h0001;
      end
      return r;
   endfunction

   function automatic logic [15:0] offset_addr(input logic [15:0] p,
                                               input logic [5:0] k);
      return p + {{10{k[5]}}, k};
   endfunction

   function automatic logic [31:0] status_word(input state_t s);
      logic [31:0] r;
      r = 32'h0000_0000;
      r[7:0] = s.working;
      r[8] = s.carry;
      r[9] = s.zero;
      r[20:16] = s.bank_select_register;
      r[30:24] = s.program_counter_high_latch;
      return r;
   endfunction

   function automatic logic [31:0] read_word(input logic [APB_AW-1:0] a,
                                             input state_t s,
                                             input logic [7:0] b);
      logic [31:0] r;
      case (a)
         OFF_STATUS: r = status_word(s);
         OFF_PTR0: r = {16'h0000, s.ptr0};
         OFF_PTR1: r = {16'h0000, s.ptr1};
         OFF_MEM_ADDR: r = {16'h0000, s.mem_addr};
         OFF_MEM_DATA: r = {24'h00_0000, b};
         default: r = 32'h0000_0000;
      endcase
      return r;
   endfunction

   function automatic state_t put_ptr(input state_t s, input logic sel,
                                      input logic [15:0] p);
      state_t r;
      r = s;
      if (sel) begin
         r.ptr1 = p;
      end else begin
         r.ptr0 = p;
      end
      return r;
   endfunction

   // ==========================================
   // storage
   logic [7:0] mem [DEPTH];
   state_t state;
   state_t next_state;
   cmd_t cmd;
   logic access;
   logic mem_we;
   logic [AW-1:0] mem_wa;
   logic [7:0] mem_wd;
   logic [15:0] dir_addr;
   logic [7:0] src;
   logic [7:0] shifted;
   logic [15:0] ptr;
   logic [15:0] stepped;
   logic [15:0] eff_addr;
   logic [7:0] loaded;
   logic [6:0] f_addr;
   logic [5:0] rel_off;
   logic [4:0] k5;
   logic [6:0] k7;
   logic down;
   logic post;

   // ==========================================
   // next state
   always_comb begin
      next_state = state;
      cmd = cmd_t'(PWDATA);
      mem_we = 1'b0;
      mem_wa = '0;
      mem_wd = '0;
      access = PSEL & PENABLE & state.ready;

      // ==========================================
      // operand fields
      f_addr = cmd.operand[6:0];
      rel_off = cmd.operand[5:0];
      k5 = cmd.operand[4:0];
      k7 = cmd.operand[6:0];
      down = cmd.pointer_update_mode[0];
      post = cmd.pointer_update_mode[1];

      // ==========================================
      // operand fetch
      dir_addr = file_addr(state.bank_select_register, f_addr,
                           state.ptr0, state.ptr1);
      src = mem[mem_index(dir_addr)];
      shifted = shift_right(src);
      ptr = cmd.ptr_sel ? state.ptr1 : state.ptr0;
      stepped = step_ptr(ptr, down);
      if (cmd.relative) begin
         eff_addr = offset_addr(ptr, rel_off);
      end else if (post) begin
         eff_addr = ptr;
      end else begin
         eff_addr = stepped;
      end
      loaded = mem[mem_index(eff_addr)];

      // ==========================================
      // bus answer: setup edge prepares it, access lasts one cycle
      next_state.ready = PSEL & ~PENABLE;
      next_state.slverr = PSEL & ~PENABLE & ~mapped(PADDR);
      if (PSEL && !PENABLE) begin
         next_state.rdata = read_word(PADDR, state,
                                      mem[mem_index(state.mem_addr)]);
      end

      // ==========================================
      // writes take effect at the completing edge only
      if (access && PWRITE) begin
         case (PADDR)
            OFF_PTR0: next_state.ptr0 = PWDATA[15:0];
            OFF_PTR1: next_state.ptr1 = PWDATA[15:0];
            OFF_MEM_ADDR: next_state.mem_addr = PWDATA[15:0];
            OFF_MEM_DATA: begin
               mem_we = 1'b1;
               mem_wa = mem_index(state.mem_addr);
               mem_wd = PWDATA[7:0];
            end
            OFF_CMD: begin
               // one instruction per command write
               case (cmd.op)
                  OP_SHIFT_RIGHT: begin
                     next_state.carry = src[0];
                     next_state.zero = is_zero(shifted);
                     if (cmd.dest) begin
                        mem_we = 1'b1;
                        mem_wa = mem_index(dir_addr);
                        mem_wd = shifted;
                     end else begin
                        next_state.working = shifted;
                     end
                  end
                  OP_INDIRECT_LOAD: begin
                     next_state.working = loaded;
                     next_state.zero = is_zero(loaded);
                     // carry untouched by stepping
                     if (!cmd.relative) begin
                        next_state = put_ptr(next_state, cmd.ptr_sel,
                                             stepped);
                     end
                  end
                  OP_LIT_BANK: begin
                     next_state.bank_select_register =
                        k5;
                  end
                  OP_LIT_LATCH: begin
                     next_state.program_counter_high_latch =
                        k7;
                  end
                  OP_LIT_WORKING: begin
                     next_state.working = cmd.operand;
                  end
                  OP_STORE_WORKING: begin
                     mem_we = 1'b1;
                     mem_wa = mem_index(dir_addr);
                     mem_wd = state.working;
                  end
                  default: begin
                  end
               endcase
            end
            default: begin
            end
         endcase
      end
   end

   // ==========================================
   // registers
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         state <= STATE_RESET;
      end else begin
         state <= next_state;
      end
   end

   // ==========================================
   // memory write port
   always_ff @(posedge CLK) begin
      if (mem_we) begin
         mem[mem_wa] <= mem_wd;
      end
   end

   // ==========================================
   // outputs
   assign PRDATA = state.rdata;
   assign PREADY = state.ready;
   assign PSLVERR = state.slverr;
endmodule

// ### verification/shift_move_chk.sv
`timescale 1ns/10ps
module shift_move_chk (
   input wire logic CLK,
   input wire logic NRST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [shift_move_pkg::APB_AW-1:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR
);
   import shift_move_pkg::*;
   // ==========
   // bus checks
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!NRST);
   sequence s_setup;
      PSEL && !PENABLE;
   endsequence
   sequence s_read(a);
      PREADY && !PWRITE && PADDR == a;
   endsequence
   a_ready_setup: assert property (s_setup |=> PREADY)
      else $error("no ready after setup");
   a_ready_pulse: assert property (PREADY |=> !PREADY)
      else $error("ready held too long");
   a_ready_access: assert property (PREADY |-> PSEL && PENABLE)
      else $error("ready outside access");
   a_err_ready: assert property (PSLVERR |-> PREADY)
      else $error("error without ready");
   a_err_once: assert property (PSLVERR |=> !PSLVERR)
      else $error("error held too long");
   a_err_unmapped: assert property (PREADY && PADDR > 8'h14 |-> PSLVERR)
      else $error("unmapped access accepted");
   a_err_data: assert property (PSLVERR && !PWRITE |-> PRDATA == 0)
      else $error("error read not zero");
   a_cmd_zero: assert property (s_read(OFF_CMD) |-> PRDATA == 0)
      else $error("command read not zero");
   a_ptr_width: assert property (s_read(OFF_PTR0) |-> PRDATA[31:16] == 0)
      else $error("pointer wider than 16 bits");
   a_status_gaps: assert property (s_read(OFF_STATUS) |->
      PRDATA[31] == 0 && PRDATA[23:21] == 0 && PRDATA[15:10] == 0)
      else $error("status spare bits set");
endmodule
bind shift_move_datapath shift_move_chk u_chk (.CLK(CLK), .NRST(NRST),
   .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
   .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR));

// ### verification/shift_move_datapath_tb.sv
`timescale 1ns/10ps
module shift_move_datapath_tb;
   import shift_move_pkg::*;
   logic CLK = 0, NRST = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, c = 0, z = 0;
   logic [7:0] PADDR = '0, w = '0, mem[256];
   logic [31:0] PWDATA = '0, PRDATA, rnd = 32'h0000_0042;
   logic PREADY, PSLVERR;
   logic [32:0] q[$];
   logic [15:0] p0 = '0, p1 = '0;
   logic [4:0] bank = '0;
   logic [6:0] pcl = '0;
   int mismatches = 0, checks_done = 0;
   always #4 CLK = ~CLK;
   shift_move_datapath #(.DEPTH(256)) dut (.CLK(CLK), .NRST(NRST),
      .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
      .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR));
   function automatic logic [31:0] xs();
      rnd ^= rnd << 13;
      rnd ^= rnd >> 17;
      rnd ^= rnd << 5;
      return rnd;
   endfunction
   task automatic final_report();
      if (mismatches == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d, input logic [32:0] e = '0);
      int n = 0;
      if (!wr) q.push_back(e);
      PSEL <= 1'b1;
      PWRITE <= wr;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      do begin
         @(posedge CLK);
         n++;
      end while (PREADY !== 1'b1 && n < 20);
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      if (n >= 20) begin
         mismatches++;
         final_report();
      end
      @(posedge CLK);
   endtask
   task automatic chk_st();
      apb(1'b0, OFF_STATUS, '0, {2'b0, pcl, 3'b0, bank, 6'b0, z, c, w});
   endtask
   // f = {dest, pointer select, mode, relative}
   task automatic exec(input logic [2:0] op, input logic [4:0] f,
      input logic [7:0] k);
      logic [7:0] a, v;
      logic [15:0] p, np, ea;
      a = k[6:0] == 0 ? p0[7:0] : k[6:0] == 1 ? p1[7:0] : {bank[0], k[6:0]};
      p = f[3] ? p1 : p0;
      np = f[1] ? p - 16'h0001 : p + 16'h0001;
      ea = f[0] ? p + {{10{k[5]}}, k[5:0]} : f[2] ? p : np;
      apb(1'b1, OFF_CMD, {5'h0, op, f, 11'h0, k});
      case (op)
         3'd1: begin
            v = {1'b0, mem[a][7:1]};
            c = mem[a][0];
            z = v == 0;
            if (f[4]) mem[a] = v;
            else w = v;
         end
         3'd2: begin
            w = mem[ea[7:0]];
            z = w == 0;
            if (!f[0] && f[3]) p1 = np;
            if (!f[0] && !f[3]) p0 = np;
         end
         3'd3: bank = k[4:0];
         3'd4: pcl = k[6:0];
         3'd5: w = k;
         3'd6: mem[a] = w;
         default: ;
      endcase
      chk_st();
      apb(1'b0, OFF_PTR0, '0, {17'h0, p0});
      apb(1'b0, OFF_PTR1, '0, {17'h0, p1});
      apb(1'b1, OFF_MEM_ADDR, {24'h0, a});
      apb(1'b0, OFF_MEM_DATA, '0, {25'h0, mem[a]});
   endtask
   always @(posedge CLK) begin
      logic [32:0] e;
      if (PSEL && PENABLE && PREADY === 1'b1 && !PWRITE) begin
         e = q.pop_front();
         checks_done++;
         if ({PSLVERR, PRDATA} !== e) begin
            mismatches++;
            $display("CHECK FAILED %0t got %h exp %h", $time,
               {PSLVERR, PRDATA}, e);
         end
      end
   end
   initial begin
      repeat (8) @(posedge CLK);
      NRST <= 1'b1;
      @(posedge CLK);
      chk_st();
      for (int i = 0; i < 256; i++) begin
         mem[i] = 8'(xs());
         apb(1'b1, OFF_MEM_ADDR, 32'(i));
         apb(1'b1, OFF_MEM_DATA, {24'h0, mem[i]});
      end
      exec(3'd5, 5'h00, 8'h00);
      p0 = 16'hFFFF;
      apb(1'b1, OFF_PTR0, 32'h0000_FFFF);
      exec(3'd2, 5'h00, 8'h00);
      exec(3'd2, 5'h0E, 8'h00);
      for (int m = 0; m < 4; m++) exec(3'd2, 5'(m * 2), 8'h00);
      exec(3'd2, 5'h09, 8'h20);
      exec(3'd2, 5'h01, 8'h1F);
      exec(3'd1, 5'h10, 8'h00);
      exec(3'd6, 5'h00, 8'h01);
      exec(3'd3, 5'h00, 8'h1F);
      exec(3'd6, 5'h00, 8'h7F);
      apb(1'b1, OFF_STATUS, 32'hFFFF_FFFF);
      chk_st();
      apb(1'b0, 8'h18, '0, {1'b1, 32'h0});
      apb(1'b0, OFF_CMD, '0, 33'h0);
      repeat (300) exec(3'(1 + xs() % 6), 5'(xs()), 8'(xs()));
      final_report();
   end
endmodule
